// >>> shared/stepper_status_defines.svh
// Register offsets, field positions, reset values and table sizes for the status block
`ifndef STEPPER_STATUS_DEFINES_SVH
`define STEPPER_STATUS_DEFINES_SVH
`define ADDR_PEAK_CTRL    7'h01
`define ADDR_MODE_CTRL    7'h02
`define ADDR_LIVE_FAULT   7'h04
`define ADDR_X_OVERAMP    7'h05
`define ADDR_Y_THERMAL    7'h06
`define ADDR_STEP_POS     7'h07
`define MODE_WATCHDOG_ENABLE_BIT_BIT     7
`define MODE_STEP_POL_BIT 1
`define MODE_DIR_CTRL_BIT 0
`define PEAK_CODE_RST     5'h00
`define STATUS_RST        8'h00
`define STEP_POS_RST      7'h00
`define PEAK_TABLE_SIZE   32
`endif

// >>> shared/stepper_status_pkg.sv
// Types shared by the status block and its bench
package stepper_status_pkg;
  typedef struct packed {
    logic       thermalWarning;
    logic       chargePumpFault;
    logic       coilXBreak;
    logic       coilYBreak;
    logic [3:0] xOveramp;  // pos top, pos bottom, neg top, neg bottom
    logic [3:0] yOveramp;  // pos top, pos bottom, neg top, neg bottom
    logic       thermalShutdown;
  } fault_in_t;
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } link_req_t;
  typedef enum logic [0:0] {
    LINK_IDLE = 1'b0,
    LINK_WAIT = 1'b1
  } link_state_t;
endpackage

// >>> verilog/stepper_driver_status_regs.sv
// Status and control registers of the stepper driver, with link access and micro-step translator
// Contract
// [R1] The 5-bit peak amps code selects coil amplitude, 66 mA up to 3015 mA.
// [R2] Controller should lower peak code across ranges carefully; overcurrent may be reported.
// [R3] Four read-only status registers read all zero after power-on or hard reset.
// [R4] Status registers sit at 04h to 07h with a check bit in bit 7.
// [R5] Register 04h shows live thermal warning, pump fault, watchdog, coil X, coil Y.
// [R6] Each coil break flag reads one exactly while its winding is open.
// [R7] Register 05h latches X-bridge overcurrent for four transistors in bits 6 to 3.
// [R8] Register 06h latches Y-bridge overcurrent bits 6 to 3, thermal shutdown bit 2.
// [R9] Register 07h shows the live 7-bit micro-step position, reset to zero.
// [R10] A watchdog time-out sets the watchdog event flag.
// [R11] Watchdog flag clears only when zero is written to the watchdog enable bit.
// [R12] Translator advances on rising step edge, or falling when polarity bit set.
// [R13] Direction is direction pin XOR direction control bit.
// [R14] Check bit gives even parity over the other seven bits.
// [R15] Latched overcurrent and shutdown flags hold until that register is read.
`timescale 1ns/100ps
`include "stepper_status_defines.svh"
module stepper_driver_status_regs (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic                          linkClk,
  input  wire stepper_status_pkg::fault_in_t faultPins,
  input  wire logic                          watchdogTimeout,
  input  wire logic                          stepAdvancePin,
  input  wire logic                          dirPin,
  input  wire logic                          linkRdEn,
  input  wire logic                          linkWrEn,
  input  wire logic [6:0]                    linkAddr,
  input  wire logic [7:0]                    linkWrData,
  output logic                               linkReady,
  output logic                               linkRdValid,
  output logic [7:0]                         linkRdData,
  output logic [4:0]                         peakAmpsCode,
  output logic [11:0]                        coilPeakAmplitude,
  output logic [6:0]                         microstepPosition
);
  import stepper_status_pkg::*;

  localparam int PIN_W = 16;
  // Typical amplitude in mA for each peak amps code
  localparam logic [11:0] AMPS_TABLE [`PEAK_TABLE_SIZE] = '{
    12'd66, 12'd135, 12'd189, 12'd200, 12'd221, 12'd244, 12'd269, 12'd297,
    12'd328, 12'd366, 12'd400, 12'd442, 12'd488, 12'd538, 12'd594, 12'd654,
    12'd735, 12'd800, 12'd883, 12'd975, 12'd1077, 12'd1189, 12'd1255, 12'd1485,
    12'd1625, 12'd1767, 12'd1950, 12'd2153, 12'd2378, 12'd2552, 12'd2775, 12'd3015};

  // Check bit prepended to seven data bits
  function automatic logic [7:0] withCheck(input logic [6:0] d);
    withCheck = {^d, d};  // see [R14]
  endfunction

  // Reset release, one synchroniser per domain
  logic [1:0] rstPipe;
  logic [1:0] linkRstPipe;
  logic       rstN;
  logic       linkRstN;
  assign rstN     = rstPipe[1];
  assign linkRstN = linkRstPipe[1];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rstPipe <= 2'b00;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) linkRstPipe <= 2'b00;
    else linkRstPipe <= {linkRstPipe[0], 1'b1};
  end

  // Pins are asynchronous; two flops before any logic looks at them
  logic [PIN_W-1:0] pinMeta;
  logic [PIN_W-1:0] pinSync;
  fault_in_t        flt;
  logic             wdPin;
  logic             stepPin;
  logic             dirSync;
  assign {flt, wdPin, stepPin, dirSync} = pinSync;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= {faultPins, watchdogTimeout, stepAdvancePin, dirPin};
      pinSync <= pinMeta;
    end
  end

  // Link-side request holding register and handshake state
  link_state_t linkState;
  link_state_t next_linkState;
  link_req_t   linkReq;
  link_req_t   next_linkReq;
  logic        reqTog;
  logic        next_reqTog;
  logic        ackMeta;
  logic        ackSync;
  logic        ackSeen;
  logic        next_linkReady;
  logic        next_linkRdValid;
  logic [7:0]  next_linkRdData;
  logic        ackTog;
  logic [7:0]  rdData;

  // Request word is held stable until the answer returns, so the sys side can sample it freely
  always_comb begin
    next_linkState   = linkState;
    next_linkReq     = linkReq;
    next_reqTog      = reqTog;
    next_linkRdValid = 1'b0;
    next_linkRdData  = linkRdData;
    case (linkState)
      LINK_IDLE: begin
        if (linkReady && (linkRdEn || linkWrEn)) begin  // Nothing is taken while ready is low, even after reset
          next_linkReq   = '{write: linkWrEn, addr: linkAddr, data: linkWrData};
          next_reqTog    = ~reqTog;
          next_linkState = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        if (ackSync != ackSeen) begin
          next_linkRdData  = rdData;
          next_linkRdValid = ~linkReq.write;
          next_linkState   = LINK_IDLE;
        end
      end
      default: next_linkState = LINK_IDLE;
    endcase
    next_linkReady = (next_linkState == LINK_IDLE);
  end

  always_ff @(posedge linkClk or negedge linkRstN) begin
    if (!linkRstN) begin
      linkState   <= LINK_IDLE;
      linkReq     <= '0;
      reqTog      <= 1'b0;
      ackMeta     <= 1'b0;
      ackSync     <= 1'b0;
      ackSeen     <= 1'b0;
      linkReady   <= 1'b0;
      linkRdValid <= 1'b0;
      linkRdData  <= `STATUS_RST;
    end else begin
      linkState   <= next_linkState;
      linkReq     <= next_linkReq;
      reqTog      <= next_reqTog;
      ackMeta     <= ackTog;
      ackSync     <= ackMeta;
      ackSeen     <= ackSync;
      linkReady   <= next_linkReady;
      linkRdValid <= next_linkRdValid;
      linkRdData  <= next_linkRdData;
    end
  end

  // Sys-side register state
  logic       reqMeta;
  logic       reqSync;
  logic       reqSeen;
  logic       reqEvent;
  logic       wdEnable;
  logic       stepPol;
  logic       dirCtrl;
  logic       wdFlag;
  logic [3:0] xOver;
  logic [3:0] yOver;
  logic       tsdFlag;
  logic       stepPrev;
  logic       next_ackTog;
  logic [7:0] next_rdData;
  logic [4:0] next_peakAmpsCode;
  logic       next_wdEnable;
  logic       next_stepPol;
  logic       next_dirCtrl;
  logic       next_wdFlag;
  logic [3:0] next_xOver;
  logic [3:0] next_yOver;
  logic       next_tsdFlag;
  logic [6:0] next_microstep;
  logic       rdX;
  logic       rdY;
  logic       wdClear;
  logic       advance;
  logic       reverse;

  assign reqEvent = reqSync ^ reqSeen;
  assign rdX      = reqEvent && !linkReq.write && linkReq.addr == `ADDR_X_OVERAMP;
  assign rdY      = reqEvent && !linkReq.write && linkReq.addr == `ADDR_Y_THERMAL;
  assign wdClear  = reqEvent && linkReq.write && linkReq.addr == `ADDR_MODE_CTRL
                    && !linkReq.data[`MODE_WATCHDOG_ENABLE_BIT_BIT];  // see [R11]
  assign advance  = stepPol ? (stepPrev && !stepPin) : (!stepPrev && stepPin);  // see [R12]
  assign reverse  = dirSync ^ dirCtrl;  // see [R13]

  // Register access, sticky flags and translator; a new fault wins over a same-cycle clear
  always_comb begin
    next_ackTog       = ackTog;
    next_rdData       = rdData;
    next_peakAmpsCode = peakAmpsCode;
    next_wdEnable     = wdEnable;
    next_stepPol      = stepPol;
    next_dirCtrl      = dirCtrl;
    if (reqEvent) begin
      next_ackTog = ~ackTog;
      if (linkReq.write) begin
        case (linkReq.addr)
          `ADDR_PEAK_CTRL: next_peakAmpsCode = linkReq.data[4:0];  // see [R1]
          `ADDR_MODE_CTRL: begin
            next_wdEnable = linkReq.data[`MODE_WATCHDOG_ENABLE_BIT_BIT];
            next_stepPol  = linkReq.data[`MODE_STEP_POL_BIT];
            next_dirCtrl  = linkReq.data[`MODE_DIR_CTRL_BIT];
          end
          default: next_wdEnable = wdEnable;  // Status space is read-only
        endcase
      end else begin
        case (linkReq.addr)  // see [R4]
          `ADDR_PEAK_CTRL:  next_rdData = {3'b000, peakAmpsCode};
          `ADDR_MODE_CTRL:  next_rdData = {wdEnable, 5'b00000, stepPol, dirCtrl};
          `ADDR_LIVE_FAULT: next_rdData = withCheck({flt.thermalWarning, flt.chargePumpFault, wdFlag,
                                                     flt.coilXBreak, flt.coilYBreak, 2'b00});  // see [R5] [R6]
          `ADDR_X_OVERAMP:  next_rdData = withCheck({xOver, 3'b000});  // see [R7]
          `ADDR_Y_THERMAL:  next_rdData = withCheck({yOver, tsdFlag, 2'b00});  // see [R8]
          `ADDR_STEP_POS:   next_rdData = withCheck(microstepPosition);  // see [R9]
          default:          next_rdData = `STATUS_RST;
        endcase
      end
    end
    next_wdFlag  = (wdFlag && !wdClear) || wdPin;  // see [R10] [R11]
    next_xOver   = (rdX ? 4'h0 : xOver) | flt.xOveramp;  // see [R15]
    next_yOver   = (rdY ? 4'h0 : yOver) | flt.yOveramp;  // see [R15]
    next_tsdFlag = (tsdFlag && !rdY) || flt.thermalShutdown;
    next_microstep = microstepPosition;
    if (advance) begin
      next_microstep = reverse ? microstepPosition - 7'h01 : microstepPosition + 7'h01;
    end
  end

  // The first request flop feeds only the second; logic reads the second and third for the edge
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      reqMeta           <= 1'b0;
      reqSync           <= 1'b0;
      reqSeen           <= 1'b0;
      ackTog            <= 1'b0;
      rdData            <= `STATUS_RST;
      peakAmpsCode      <= `PEAK_CODE_RST;
      coilPeakAmplitude <= AMPS_TABLE[0];
      wdEnable          <= 1'b0;
      stepPol           <= 1'b0;
      dirCtrl           <= 1'b0;
      wdFlag            <= 1'b0;  // see [R3]
      xOver             <= 4'h0;
      yOver             <= 4'h0;
      tsdFlag           <= 1'b0;
      stepPrev          <= 1'b0;
      microstepPosition <= `STEP_POS_RST;
    end else begin
      reqMeta           <= reqTog;
      reqSync           <= reqMeta;
      reqSeen           <= reqSync;
      ackTog            <= next_ackTog;
      rdData            <= next_rdData;
      peakAmpsCode      <= next_peakAmpsCode;
      coilPeakAmplitude <= AMPS_TABLE[next_peakAmpsCode];  // see [R1]
      wdEnable          <= next_wdEnable;
      stepPol           <= next_stepPol;
      dirCtrl           <= next_dirCtrl;
      wdFlag            <= next_wdFlag;
      xOver             <= next_xOver;
      yOver             <= next_yOver;
      tsdFlag           <= next_tsdFlag;
      stepPrev          <= stepPin;
      microstepPosition <= next_microstep;
    end
  end

  // Checks on the sys domain
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN);

  property p_amp_table;
    coilPeakAmplitude == AMPS_TABLE[peakAmpsCode];
  endproperty
  a_amp_table: assert property (p_amp_table) else $error("amplitude mismatch");  // see [R1]
  property p_reset_zero;
    $rose(rstN) |-> (xOver == 4'h0 && yOver == 4'h0 && !tsdFlag && !wdFlag && microstepPosition == 7'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");  // see [R3]
  property p_status_parity;
    reqEvent && !linkReq.write && linkReq.addr[6:2] == 5'h01 |=> ^rdData == 1'b0;
  endproperty
  a_status_parity: assert property (p_status_parity) else $error("bad check bit");  // see [R4] [R14]
  property p_live_map;
    reqEvent && !linkReq.write && linkReq.addr == `ADDR_LIVE_FAULT
      |=> rdData[6:2] == {$past(flt.thermalWarning), $past(flt.chargePumpFault), $past(wdFlag),
                          $past(flt.coilXBreak), $past(flt.coilYBreak)};
  endproperty
  a_live_map: assert property (p_live_map) else $error("live fault read wrong");  // see [R5] [R6]
  property p_x_set;
    flt.xOveramp != 4'h0 |=> (xOver & $past(flt.xOveramp)) == $past(flt.xOveramp);
  endproperty
  a_x_set: assert property (p_x_set) else $error("x overcurrent not latched");  // see [R7]
  property p_y_hold;
    !rdY |=> (yOver & $past(yOver)) == $past(yOver) && (tsdFlag || !$past(tsdFlag));
  endproperty
  a_y_hold: assert property (p_y_hold) else $error("y flags dropped without read");  // see [R8] [R15]
  property p_x_read_clear;
    rdX && flt.xOveramp == 4'h0 |=> xOver == 4'h0;
  endproperty
  a_x_read_clear: assert property (p_x_read_clear) else $error("x flags not cleared by read");  // see [R15]
  property p_wd_set;
    wdPin |=> wdFlag ##1 (wdFlag || $past(wdClear));
  endproperty
  a_wd_set: assert property (p_wd_set) else $error("watchdog flag not set");  // see [R10]
  property p_wd_hold;
    wdFlag && !wdClear |=> wdFlag;
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("watchdog flag lost");  // see [R11]
  property p_step;
    advance |=> microstepPosition == ($past(reverse) ? $past(microstepPosition) - 7'h01
                                                     : $past(microstepPosition) + 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("step position wrong");  // see [R12] [R13]
  property p_no_step;
    !advance |=> $stable(microstepPosition);
  endproperty
  a_no_step: assert property (p_no_step) else $error("position moved without step");  // see [R9]

  c_step_reverse: cover property (advance && reverse);
  c_wd_cleared: cover property (wdFlag && wdClear ##1 !wdFlag);
  c_x_read_clear: cover property (xOver != 4'h0 ##1 rdX ##1 xOver == 4'h0);
  c_falling_step: cover property (stepPol && advance);
endmodule

// >>> dv/link_host_model.sv
// Link master model standing in for the controller beyond the status block
`timescale 1ns/100ps
module link_host_model (
  input  wire logic       linkClk,
  input  wire logic       linkReady,
  input  wire logic       linkRdValid,
  input  wire logic [7:0] linkRdData,
  output logic            linkRdEn,
  output logic            linkWrEn,
  output logic [6:0]      linkAddr,
  output logic [7:0]      linkWrData
);
  // Idle bus at time zero
  initial begin
    linkRdEn   = 1'b0;
    linkWrEn   = 1'b0;
    linkAddr   = 7'h00;
    linkWrData = 8'h00;
  end
  // One request at a time; released lines invert so stale values never look valid
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic ok);
    int ph;
    ph = 0;
    ok = 1'b0;
    rd = 8'h00;
    @(posedge linkClk);
    #1;
    linkWrEn   = wr;
    linkRdEn   = !wr;
    linkAddr   = a;
    linkWrData = d;
    for (int n = 0; n < 200 && ph < 3; n++) begin
      @(posedge linkClk);
      if (ph == 0 && linkReady === 1'b1) begin
        ph = 1;
        #1;
        linkWrEn   = 1'b0;
        linkRdEn   = 1'b0;
        linkAddr   = ~linkAddr;
        linkWrData = ~linkWrData;
      end else if (ph == 1 && linkReady === 1'b0) begin
        ph = 2;
      end else if (ph == 2 && linkReady === 1'b1) begin
        ph = 3;
        rd = linkRdData;
        ok = wr ? (linkRdValid === 1'b0) : (linkRdValid === 1'b1);  // Writes answer without a data pulse
      end
    end
  endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the stepper driver status registers
`timescale 1ns/100ps
`include "stepper_status_defines.svh"
module tb_top;
  import stepper_status_pkg::*;
  logic      sys_clk         = 1'b0;
  logic      linkClk         = 1'b0;
  logic      nrst            = 1'b1;
  fault_in_t faultPins       = '0;
  logic      watchdogTimeout = 1'b0;
  logic      stepAdvancePin  = 1'b0;
  logic      dirPin          = 1'b0;
  logic        linkRdEn, linkWrEn, linkReady, linkRdValid;
  logic [6:0]  linkAddr, microstepPosition, expPos;
  logic [7:0]  linkWrData, linkRdData;
  logic [4:0]  peakAmpsCode;
  logic [11:0] coilPeakAmplitude;
  int n_fail   = 0;
  int compares = 0;
  // Typical amplitude in mA per peak code
  int ampTable [32] = '{66, 135, 189, 200, 221, 244, 269, 297, 328, 366, 400, 442, 488, 538, 594, 654,
                        735, 800, 883, 975, 1077, 1189, 1255, 1485, 1625, 1767, 1950, 2153, 2378, 2552,
                        2775, 3015};
  // Clocks; rising edges of the 6 ns and 20 ns clocks never coincide, so no race hides a crossing fault
  always #10 sys_clk = ~sys_clk;
  always #3 linkClk = ~linkClk;
  stepper_driver_status_regs i_dut (.sys_clk(sys_clk), .nrst(nrst), .linkClk(linkClk), .faultPins(faultPins),
    .watchdogTimeout(watchdogTimeout), .stepAdvancePin(stepAdvancePin), .dirPin(dirPin), .linkRdEn(linkRdEn),
    .linkWrEn(linkWrEn), .linkAddr(linkAddr), .linkWrData(linkWrData), .linkReady(linkReady),
    .linkRdValid(linkRdValid), .linkRdData(linkRdData), .peakAmpsCode(peakAmpsCode),
    .coilPeakAmplitude(coilPeakAmplitude), .microstepPosition(microstepPosition));
  link_host_model i_host (.linkClk(linkClk), .linkReady(linkReady), .linkRdValid(linkRdValid),
    .linkRdData(linkRdData), .linkRdEn(linkRdEn), .linkWrEn(linkWrEn), .linkAddr(linkAddr),
    .linkWrData(linkWrData));
  // Verdict and end of run
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected status byte: even check bit over the seven data bits
  function automatic logic [7:0] par(input logic [6:0] v);
    return {^v, v};
  endfunction
  task automatic sysWait(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Link accesses; a hung transfer ends the run
  task automatic regWr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    logic       ok;
    i_host.xfer(1'b1, a, d, rd, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic regChk(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    logic       ok;
    i_host.xfer(1'b0, a, 8'h00, rd, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      print_verdict();
    end else begin
      chk(what, {4'h0, exp}, {4'h0, rd});
    end
  endtask
  // Reset values, a write to a read-only register, an unmapped read
  task automatic scnReset;
    regWr(`ADDR_X_OVERAMP, 8'hFF);
    for (int a = 4; a < 8; a++) regChk("status reset", 7'(a), 8'h00);
    regChk("unmapped", 7'h7F, 8'h00);
    chk("code reset", 12'h000, {7'h00, peakAmpsCode});
    chk("amp reset", 12'h042, coilPeakAmplitude);
    chk("pos reset", 12'h000, {5'h00, microstepPosition});
  endtask
  // Every peak code, raised only, never lowered across a range
  task automatic scnPeak;
    for (int i = 0; i < 32; i++) begin
      regWr(`ADDR_PEAK_CTRL, {3'b000, 5'(i)});
      sysWait(2);
      chk("peak code", 12'(i), {7'h00, peakAmpsCode});
      chk("peak amp", 12'(ampTable[i]), coilPeakAmplitude);
      regChk("peak reg", `ADDR_PEAK_CTRL, {3'b000, 5'(i)});
    end
  endtask
  // Live flags follow the pins both ways
  task automatic scnLive;
    logic [3:0] pat [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF, 4'h0};
    foreach (pat[i]) begin
      {faultPins.thermalWarning, faultPins.chargePumpFault, faultPins.coilXBreak, faultPins.coilYBreak} = pat[i];
      sysWait(4);
      regChk("live", `ADDR_LIVE_FAULT, par({pat[i][3:2], 1'b0, pat[i][1:0], 2'b00}));
    end
  endtask
  // Latched flags survive the fault and clear on read
  task automatic scnLatch;
    for (int i = 0; i < 4; i++) begin
      faultPins.xOveramp = 4'b1000 >> i;
      sysWait(4);
      faultPins.xOveramp = 4'h0;
      sysWait(2);
      regChk("x latch", `ADDR_X_OVERAMP, par({4'b1000 >> i, 3'b000}));
      regChk("x clear", `ADDR_X_OVERAMP, 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      {faultPins.yOveramp, faultPins.thermalShutdown} = 5'b10000 >> i;
      sysWait(4);
      {faultPins.yOveramp, faultPins.thermalShutdown} = 5'h00;
      sysWait(2);
      regChk("y latch", `ADDR_Y_THERMAL, par({5'b10000 >> i, 2'b00}));
      regChk("y clear", `ADDR_Y_THERMAL, 8'h00);
    end
  endtask
  // Watchdog flag sticks through reads and other writes
  task automatic scnWatchdog;
    watchdogTimeout = 1'b1;
    sysWait(4);
    watchdogTimeout = 1'b0;
    sysWait(2);
    regChk("wd set", `ADDR_LIVE_FAULT, par(7'h10));
    regWr(`ADDR_MODE_CTRL, 8'h80);
    regWr(`ADDR_PEAK_CTRL, 8'h1F);
    regChk("wd kept", `ADDR_LIVE_FAULT, par(7'h10));
    regChk("mode reg", `ADDR_MODE_CTRL, 8'h80);
    regWr(`ADDR_MODE_CTRL, 8'h00);
    regChk("wd clear", `ADDR_LIVE_FAULT, 8'h00);
  endtask
  // Moves the step pin after settling direction, then checks the position
  task automatic stepTo(input logic dir, input logic lvl, input int delta);
    dirPin = dir;
    sysWait(3);
    stepAdvancePin = lvl;
    sysWait(6);
    expPos = expPos + 7'(delta);
    chk("pos pin", {5'h00, expPos}, {5'h00, microstepPosition});
    regChk("pos reg", `ADDR_STEP_POS, par(expPos));
  endtask
  // Both polarities, both direction sources, wrap below zero
  task automatic scnStep;
    expPos = 7'h00;
    stepTo(1'b1, 1'b1, -1);
    stepTo(1'b1, 1'b0, 0);
    stepTo(1'b0, 1'b1, 1);
    stepTo(1'b0, 1'b0, 0);
    regWr(`ADDR_MODE_CTRL, 8'h02);
    stepTo(1'b0, 1'b1, 0);
    stepTo(1'b0, 1'b0, 1);
    regWr(`ADDR_MODE_CTRL, 8'h03);
    stepTo(1'b1, 1'b1, 0);
    stepTo(1'b1, 1'b0, 1);
    regWr(`ADDR_MODE_CTRL, 8'h01);
    stepTo(1'b0, 1'b1, -1);
    stepTo(1'b0, 1'b0, 0);
  endtask
  // Hard reset in mid-run must wipe set flags, a moved position and a raised code
  task automatic scnHardReset;
    faultPins.xOveramp = 4'h2;
    watchdogTimeout    = 1'b1;
    sysWait(4);
    faultPins.xOveramp = 4'h0;
    watchdogTimeout    = 1'b0;
    sysWait(2);
    regChk("wd before reset", `ADDR_LIVE_FAULT, par(7'h10));
    sysWait(1);
    nrst = 1'b0;
    sysWait(3);
    chk("ready in reset", 12'h000, {11'h000, linkReady});
    chk("valid in reset", 12'h000, {11'h000, linkRdValid});
    chk("rd data in reset", 12'h000, {4'h0, linkRdData});
    nrst = 1'b1;
    sysWait(4);
    for (int a = 4; a < 8; a++) regChk("status hard reset", 7'(a), 8'h00);
    chk("code hard reset", 12'h000, {7'h00, peakAmpsCode});
    chk("amp hard reset", 12'h042, coilPeakAmplitude);
    chk("pos hard reset", 12'h000, {5'h00, microstepPosition});
  endtask
  // Main sequence
  initial begin
    #1;
    nrst = 1'b0;  // A real falling edge, so the asynchronous reset acts before the first clock
    repeat (3) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    sysWait(4);
    scnReset();
    scnPeak();
    scnLive();
    scnLatch();
    scnWatchdog();
    scnStep();
    scnHardReset();
    print_verdict();
  end
endmodule
